// *** rtl/analog_mute_gate.sv ***
// gates the four analog mute sources with their enable bits.
// assumes all source inputs are synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module analog_mute_gate
	import dac_mode_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [3:0] src_en_i,
	input  wire logic       clk_halt_i,
	input  wire logic       async_detect_i,
	input  wire logic       zero_left_i,
	input  wire logic       zero_right_i,
	input  wire logic       dac_disable_i,
	output logic            analog_mute_o
);

	typedef struct packed {
		logic mute;
	} gate_state_t;

	gate_state_t st_r;
	gate_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.mute = (src_en_i[0] & clk_halt_i)
			| (src_en_i[1] & async_detect_i)
			| (src_en_i[2] & zero_left_i & zero_right_i)
			| (src_en_i[3] & dac_disable_i);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign analog_mute_o = st_r.mute;

endmodule : analog_mute_gate

`default_nettype wire

// *** rtl/dac_mode_control_registers.sv ***
// mode control register bank of a stereo audio dac.
// assumes a serial control front end that delivers whole bytes as
// one-cycle strobes, synchronous to the system clock clk_i.
`timescale 1ns/100ps
`default_nettype none

module dac_mode_control_registers
	import dac_mode_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       sw_mode_i,
	input  wire logic       bank_addr_hi_i,
	input  wire logic       bank_addr_lo_i,
	input  wire logic       idx_load_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] byte_i,
	output logic            ack_o,
	output logic [7:0]      rdata_o,
	input  wire logic       zero_left_i,
	input  wire logic       zero_right_i,
	input  wire logic       clk_halt_i,
	input  wire logic       async_detect_i,
	output logic [1:0]      sample_rate_sel_o,
	output logic            power_save_sel_o,
	output logic [2:0]      audio_format_sel_o,
	output logic            dac_disable_o,
	output logic            rolloff_sel_o,
	output logic [1:0]      output_invert_o,
	output logic [1:0]      soft_mute_en_o,
	output logic            atten_step_sel_o,
	output logic [1:0]      deemph_rate_sel_o,
	output logic [7:0]      left_atten_level_o,
	output logic [7:0]      right_atten_level_o,
	output logic            sys_resync_o,
	output logic            regs_default_o,
	output logic            analog_mute_o,
	output logic            zero1_o,
	output logic            zero2_o
);

	bank_state_t st_r;
	bank_state_t st_nxt;

	logic [1:0] bank_sel;
	logic       addr_ok;
	logic       idx_ok;
	logic       wr_go;
	logic       rd_go;
	logic [4:0] wr_reg;
	logic [7:0] wb;

	// true when the register base number exists in the map
	function automatic logic known_reg(input logic [4:0] r);
		logic k;
		k = 1'b0;
		if (r == OFS_RESET_MUTE_RATE) begin
			k = 1'b1;
		end else if (r == OFS_POWER_SAVE_FORMAT) begin
			k = 1'b1;
		end else if (r == OFS_OPERATION_FILTER) begin
			k = 1'b1;
		end else if (r == OFS_OUTPUT_PHASE) begin
			k = 1'b1;
		end else if (r == OFS_SOFT_MUTE) begin
			k = 1'b1;
		end else if (r == OFS_SILENCE_STATUS) begin
			k = 1'b1;
		end else if (r == OFS_ATTEN_DEEMPH_FLAG) begin
			k = 1'b1;
		end else if (r == OFS_LEFT_ATTEN) begin
			k = 1'b1;
		end else if (r == OFS_RIGHT_ATTEN) begin
			k = 1'b1;
		end
		return k;
	endfunction : known_reg

	// address is defined when its bank bits match the pins and its base number exists in the map
	function automatic logic addr_defined(
		input logic [6:0] a,
		input logic [1:0] bank
	);
		return (a[6:5] == bank) && known_reg(a[4:0]);
	endfunction : addr_defined

	// read value of a register, reserved bits as zero
	function automatic logic [7:0] read_reg(
		input logic [4:0]  r,
		input bank_state_t s
	);
		logic [7:0] v;
		v = 8'h00;
		if (r == OFS_RESET_MUTE_RATE) begin
			v[POS_REGS_DEFAULT_N] = 1'b1;
			v[POS_SYS_RESYNC_N]   = 1'b1;
			v[POS_AMUTE_LSB +: 4] = s.amute;
			v[POS_SRATE_LSB +: 2] = s.srate;
		end else if (r == OFS_POWER_SAVE_FORMAT) begin
			v[POS_POWER_SAVE]      = s.psave;
			v[POS_FORMAT_LSB +: 3] = s.fmt;
		end else if (r == OFS_OPERATION_FILTER) begin
			v[POS_DAC_DISABLE] = s.dis;
			v[POS_ROLLOFF]     = s.roll;
		end else if (r == OFS_OUTPUT_PHASE) begin
			v[POS_PAIR_LSB +: 2] = s.inv;
		end else if (r == OFS_SOFT_MUTE) begin
			v[POS_PAIR_LSB +: 2] = s.smute;
		end else if (r == OFS_SILENCE_STATUS) begin
			v[POS_PAIR_LSB +: 2] = s.zero;
		end else if (r == OFS_ATTEN_DEEMPH_FLAG) begin
			v[POS_ATTEN_STEP]      = s.astep;
			v[POS_DEEMPH_LSB +: 2] = s.demp;
			v[POS_FLAG_PIN_FUNC]   = s.fsel;
			v[POS_FLAG_COMBO]      = s.combo;
			v[POS_FLAG_POLARITY]   = s.pol;
		end else if (r == OFS_LEFT_ATTEN) begin
			v = s.attl;
		end else if (r == OFS_RIGHT_ATTEN) begin
			v = s.attr;
		end
		return v;
	endfunction : read_reg

	// restores every mode field to its default
	function automatic bank_state_t set_defaults(input bank_state_t s);
		bank_state_t d;
		d       = s;
		d.amute = RST_AMUTE;
		d.srate = RST_SRATE;
		d.fmt   = RST_FORMAT;
		d.psave = RST_POWER_SAVE;
		d.dis   = RST_DAC_DISABLE;
		d.roll  = RST_ROLLOFF;
		d.inv   = RST_INVERT;
		d.smute = RST_SOFT_MUTE;
		d.demp  = RST_DEEMPH;
		d.astep = RST_ATTEN_STEP;
		d.pol   = RST_FLAG_POL;
		d.combo = RST_FLAG_COMBO;
		d.fsel  = RST_FLAG_FUNC;
		d.attl  = RST_ATTEN_LEVEL;
		d.attr  = RST_ATTEN_LEVEL;
		return d;
	endfunction : set_defaults

	// applies one data byte to the fields of register r
	function automatic bank_state_t write_reg(
		input logic [4:0]  r,
		input logic [7:0]  b,
		input bank_state_t s
	);
		bank_state_t w;
		w = s;
		if (r == OFS_RESET_MUTE_RATE) begin
			w.amute = b[POS_AMUTE_LSB +: 4];
			w.srate = b[POS_SRATE_LSB +: 2];
		end else if (r == OFS_POWER_SAVE_FORMAT) begin
			w.psave = b[POS_POWER_SAVE];
			w.fmt   = b[POS_FORMAT_LSB +: 3];
		end else if (r == OFS_OPERATION_FILTER) begin
			w.dis  = b[POS_DAC_DISABLE];
			w.roll = b[POS_ROLLOFF];
		end else if (r == OFS_OUTPUT_PHASE) begin
			w.inv = b[POS_PAIR_LSB +: 2];
		end else if (r == OFS_SOFT_MUTE) begin
			w.smute = b[POS_PAIR_LSB +: 2];
		end else if (r == OFS_ATTEN_DEEMPH_FLAG) begin
			w.astep = b[POS_ATTEN_STEP];
			w.demp  = b[POS_DEEMPH_LSB +: 2];
			w.fsel  = b[POS_FLAG_PIN_FUNC];
			w.combo = b[POS_FLAG_COMBO];
			w.pol   = b[POS_FLAG_POLARITY];
		end else if (r == OFS_LEFT_ATTEN) begin
			w.attl = b;
		end else if (r == OFS_RIGHT_ATTEN) begin
			w.attr = b;
		end
		return w;
	endfunction : write_reg

	// self-restoring control bits of the first register
	function automatic bank_state_t apply_ctrl(
		input logic [7:0]  b,
		input bank_state_t s
	);
		bank_state_t c;
		c = s;
		c.resync = !b[POS_SYS_RESYNC_N];
		if (!b[POS_REGS_DEFAULT_N]) begin
			c        = set_defaults(c);
			c.reload = 1'b1;
		end
		return c;
	endfunction : apply_ctrl

	function automatic logic [6:0] next_index(
		input logic [6:0] i
	);
		logic [6:0] n;
		if (i == IDX_WRAP_TOP) begin
			n = IDX_WRAP_BASE;
		end else begin
			n = i + 7'h01;
		end
		return n;
	endfunction : next_index

	assign bank_sel = {bank_addr_hi_i, bank_addr_lo_i};

	assign addr_ok = addr_defined(byte_i[6:0], bank_sel) && !byte_i[7];
	assign idx_ok  = addr_defined(st_r.idx, bank_sel);

	assign wr_go  = sw_mode_i && wr_i && idx_ok;
	assign rd_go  = sw_mode_i && rd_i && idx_ok;
	assign wr_reg = st_r.idx[4:0];

	// reserved bits dropped by the field selects in write_reg
	assign wb = byte_i;

	always_comb begin
		ack_o = 1'b0;
		if (sw_mode_i && idx_load_i) begin
			ack_o = addr_ok;
		end else if (sw_mode_i && (wr_i || rd_i)) begin
			ack_o = idx_ok;
		end
	end

	always_comb begin
		st_nxt        = st_r;
		st_nxt.resync = 1'b0;
		st_nxt.reload = 1'b0;
		st_nxt.zero   = {zero_right_i, zero_left_i};

		if (sw_mode_i && idx_load_i) begin
			st_nxt.idx = byte_i[6:0];
		end

		if (rd_go) begin
			st_nxt.rdata = read_reg(wr_reg, st_r);
		end

		if (wr_go) begin
			st_nxt = write_reg(wr_reg, wb, st_nxt);
			if (wr_reg == OFS_RESET_MUTE_RATE) begin
				st_nxt = apply_ctrl(wb, st_nxt);
			end
			st_nxt.idx = next_index(st_r.idx);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_r       <= set_defaults('0);
			st_r.idx   <= RST_INDEX;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o             = st_r.rdata;
	assign sample_rate_sel_o   = st_r.srate;
	assign power_save_sel_o    = st_r.psave;
	assign audio_format_sel_o  = st_r.fmt;
	assign dac_disable_o       = st_r.dis;
	assign rolloff_sel_o       = st_r.roll;
	assign output_invert_o     = st_r.inv;
	assign soft_mute_en_o      = st_r.smute;
	assign atten_step_sel_o    = st_r.astep;
	assign deemph_rate_sel_o   = st_r.demp;
	assign left_atten_level_o  = st_r.attl;
	assign right_atten_level_o = st_r.attr;
	assign regs_default_o      = st_r.reload;
	assign sys_resync_o        = st_r.resync;

	analog_mute_gate u_mute (
		.clk_i          (clk_i),
		.reset_i        (reset_i),
		.src_en_i       (st_r.amute),
		.clk_halt_i     (clk_halt_i),
		.async_detect_i (async_detect_i),
		.zero_left_i    (zero_left_i),
		.zero_right_i   (zero_right_i),
		.dac_disable_i  (st_r.dis),
		.analog_mute_o  (analog_mute_o)
	);

	zero_flag_pins u_flags (
		.clk_i         (clk_i),
		.reset_i       (reset_i),
		.zero_left_i   (zero_left_i),
		.zero_right_i  (zero_right_i),
		.combo_i       (st_r.combo),
		.polarity_i    (st_r.pol),
		.pin_func_i    (st_r.fsel),
		.analog_mute_i (analog_mute_o),
		.zero1_o       (zero1_o),
		.zero2_o       (zero2_o)
	);

endmodule : dac_mode_control_registers

`default_nettype wire

// *** rtl/dac_mode_pkg.sv ***
// holds register offsets, field positions, reset values and the state record
// of the dac mode control bank; shared by the bank and its helper modules.
package dac_mode_pkg;

	// register base numbers, before the bank offset picked by the address pins
	localparam logic [4:0] OFS_RESET_MUTE_RATE   = 5'h10;
	localparam logic [4:0] OFS_POWER_SAVE_FORMAT = 5'h11;
	localparam logic [4:0] OFS_OPERATION_FILTER  = 5'h12;
	localparam logic [4:0] OFS_OUTPUT_PHASE      = 5'h13;
	localparam logic [4:0] OFS_SOFT_MUTE         = 5'h14;
	localparam logic [4:0] OFS_SILENCE_STATUS    = 5'h15;
	localparam logic [4:0] OFS_ATTEN_DEEMPH_FLAG = 5'h16;
	localparam logic [4:0] OFS_LEFT_ATTEN        = 5'h18;
	localparam logic [4:0] OFS_RIGHT_ATTEN       = 5'h19;

	// index auto-increment wrap points
	localparam logic [6:0] IDX_WRAP_TOP  = 7'h4f;
	localparam logic [6:0] IDX_WRAP_BASE = 7'h40;

	// field positions
	localparam int POS_REGS_DEFAULT_N = 7;
	localparam int POS_SYS_RESYNC_N   = 6;
	localparam int POS_AMUTE_LSB      = 2;
	localparam int POS_SRATE_LSB      = 0;
	localparam int POS_POWER_SAVE     = 7;
	localparam int POS_FORMAT_LSB     = 0;
	localparam int POS_DAC_DISABLE    = 4;
	localparam int POS_ROLLOFF        = 0;
	localparam int POS_PAIR_LSB       = 0;
	localparam int POS_ATTEN_STEP     = 7;
	localparam int POS_DEEMPH_LSB     = 4;
	localparam int POS_FLAG_PIN_FUNC  = 3;
	localparam int POS_FLAG_COMBO     = 1;
	localparam int POS_FLAG_POLARITY  = 0;

	// reset values
	localparam logic [3:0] RST_AMUTE        = 4'h0;
	localparam logic [1:0] RST_SRATE        = 2'h0;
	localparam logic       RST_POWER_SAVE   = 1'b0;
	localparam logic [2:0] RST_FORMAT       = 3'h0;
	localparam logic       RST_DAC_DISABLE  = 1'b0;
	localparam logic       RST_ROLLOFF      = 1'b0;
	localparam logic [1:0] RST_INVERT       = 2'h0;
	localparam logic [1:0] RST_SOFT_MUTE    = 2'h0;
	localparam logic       RST_ATTEN_STEP   = 1'b0;
	localparam logic [1:0] RST_DEEMPH       = 2'h0;
	localparam logic       RST_FLAG_FUNC    = 1'b0;
	localparam logic       RST_FLAG_COMBO   = 1'b0;
	localparam logic       RST_FLAG_POL     = 1'b0;
	localparam logic [7:0] RST_ATTEN_LEVEL  = 8'hff;
	localparam logic [6:0] RST_INDEX        = 7'h00;

	// whole state of the register bank
	typedef struct packed {
		logic [6:0] idx;
		logic [3:0] amute;
		logic [1:0] srate;
		logic       psave;
		logic [2:0] fmt;
		logic       dis;
		logic       roll;
		logic [1:0] inv;
		logic [1:0] smute;
		logic [1:0] zero;
		logic       astep;
		logic [1:0] demp;
		logic       fsel;
		logic       combo;
		logic       pol;
		logic [7:0] attl;
		logic [7:0] attr;
		logic       resync;
		logic       reload;
		logic [7:0] rdata;
	} bank_state_t;

endpackage : dac_mode_pkg

// *** rtl/zero_flag_pins.sv ***
// drives the two zero flag pins from channel zero detect, combination,
// polarity and pin function; inputs synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module zero_flag_pins
	import dac_mode_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic zero_left_i,
	input  wire logic zero_right_i,
	input  wire logic combo_i,
	input  wire logic polarity_i,
	input  wire logic pin_func_i,
	input  wire logic analog_mute_i,
	output logic      zero1_o,
	output logic      zero2_o
);

	typedef struct packed {
		logic z1;
		logic z2;
	} flag_state_t;

	flag_state_t st_r;
	flag_state_t st_nxt;
	logic        det1;
	logic        det2;

	always_comb begin
		st_nxt = st_r;
		// combination a: left on first pin, right on second
		det1 = combo_i ? (zero_left_i & zero_right_i) : zero_left_i;
		det2 = combo_i ? (zero_left_i | zero_right_i) : zero_right_i;
		st_nxt.z1 = det1 ^ polarity_i;
		st_nxt.z2 = pin_func_i ? analog_mute_i : (det2 ^ polarity_i);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign zero1_o = st_r.z1;
	assign zero2_o = st_r.z2;

endmodule : zero_flag_pins

`default_nettype wire

// *** testbench/dac_mode_control_registers_assertions.sv ***
// port checker of the mode register bank.
// assumes one clock domain and the bank's synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module dac_mode_regs_checker (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       sw_mode_i,
	input  wire logic       bank_addr_hi_i,
	input  wire logic       bank_addr_lo_i,
	input  wire logic       idx_load_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       ack_o,
	input  wire logic [1:0] sample_rate_sel_o,
	input  wire logic [2:0] audio_format_sel_o,
	input  wire logic       dac_disable_o,
	input  wire logic [7:0] left_atten_level_o,
	input  wire logic [7:0] right_atten_level_o,
	input  wire logic       sys_resync_o,
	input  wire logic       regs_default_o,
	input  wire logic       zero1_o,
	input  wire logic       zero2_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sw_block_a: assert property (!sw_mode_i |-> !ack_o)
		else $error("ack outside software mode");
	bad_index_a: assert property (idx_load_i && byte_i[7] |-> !ack_o)
		else $error("ack on undefined address");
	bank_miss_a: assert property (
		idx_load_i && byte_i[6:5] != {bank_addr_hi_i, bank_addr_lo_i} |-> !ack_o)
		else $error("ack on foreign bank");
	resync_cause_a: assert property (
		$rose(sys_resync_o) |-> $past(wr_i && ack_o && !byte_i[6]) ##1 !sys_resync_o)
		else $error("resync pulse without cause");
	default_cause_a: assert property (
		regs_default_o |-> $past(wr_i && ack_o && !byte_i[7]) ##1 !regs_default_o)
		else $error("default pulse without cause");
	default_load_a: assert property (regs_default_o |-> sample_rate_sel_o == 2'h0 &&
		audio_format_sel_o == 3'h0 && !dac_disable_o && left_atten_level_o == 8'hff
		&& right_atten_level_o == 8'hff) else $error("defaults not loaded");
	resync_keep_a: assert property (sys_resync_o && !regs_default_o |->
		$stable(left_atten_level_o) && $stable(audio_format_sel_o) && $stable(dac_disable_o))
		else $error("resync changed registers");
	hold_idle_a: assert property (!$past(wr_i) && !$past(reset_i) |->
		$stable(left_atten_level_o) && $stable(right_atten_level_o))
		else $error("level changed without write");
	reset_vals_a: assert property ($past(reset_i) |-> sample_rate_sel_o == 2'h0 &&
		audio_format_sel_o == 3'h0 && left_atten_level_o == 8'hff && !zero1_o && !zero2_o)
		else $error("bad reset values");

	cover property (sys_resync_o);
	cover property (regs_default_o);
	cover property (idx_load_i && !ack_o);
endmodule : dac_mode_regs_checker

bind dac_mode_control_registers dac_mode_regs_checker u_chk (.clk_i, .reset_i, .sw_mode_i,
	.bank_addr_hi_i, .bank_addr_lo_i, .idx_load_i, .wr_i, .byte_i, .ack_o,
	.sample_rate_sel_o, .audio_format_sel_o, .dac_disable_o, .left_atten_level_o,
	.right_atten_level_o, .sys_resync_o, .regs_default_o, .zero1_o, .zero2_o);

`default_nettype wire

// *** testbench/dac_mode_control_registers_tb.sv ***
// self-checking bench of the mode register bank with a host model.
// assumes a 25 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module dac_mode_control_registers_tb;
	import dac_mode_pkg::*;
	logic       clk_i, reset_i, sw_mode_i, bank_addr_hi_i, bank_addr_lo_i;
	logic       idx_load_i, wr_i, rd_i, ack_o, zero_left_i, zero_right_i;
	logic       clk_halt_i, async_detect_i, power_save_sel_o, dac_disable_o;
	logic       rolloff_sel_o, atten_step_sel_o, sys_resync_o, regs_default_o;
	logic       analog_mute_o, zero1_o, zero2_o, a;
	logic [7:0] byte_i, rdata_o, left_atten_level_o, right_atten_level_o, d;
	logic [1:0] sample_rate_sel_o, output_invert_o, soft_mute_en_o, deemph_rate_sel_o, bank;
	logic [2:0] audio_format_sel_o;
	logic [3:0] m;
	logic [4:0] b;
	int         err_total, compares, cyc;
	logic [4:0] bases [7] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h16, 5'h18, 5'h19};
	logic [7:0] burst [4] = '{8'h05, 8'h10, 8'h02, 8'h01};

	dac_mode_control_registers DUT (.clk_i, .reset_i, .sw_mode_i, .bank_addr_hi_i,
		.bank_addr_lo_i, .idx_load_i, .wr_i, .rd_i, .byte_i, .ack_o, .rdata_o, .zero_left_i,
		.zero_right_i, .clk_halt_i, .async_detect_i, .sample_rate_sel_o, .power_save_sel_o,
		.audio_format_sel_o, .dac_disable_o, .rolloff_sel_o, .output_invert_o,
		.soft_mute_en_o, .atten_step_sel_o, .deemph_rate_sel_o, .left_atten_level_o,
		.right_atten_level_o, .sys_resync_o, .regs_default_o, .analog_mute_o, .zero1_o,
		.zero2_o);
	host_model h (.clk_i, .ack_i(ack_o), .idx_load_o(idx_load_i), .wr_o(wr_i), .rd_o(rd_i),
		.byte_o(byte_i));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic summarize();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			summarize();
		end
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// writable bits; reserved ones are sent as zero
	function automatic logic [7:0] wmask(input logic [4:0] r);
		case (r)
			5'h11: return 8'h87;
			5'h12: return 8'h11;
			5'h13, 5'h14: return 8'h03;
			5'h16: return 8'hbb;
			default: return 8'hff;
		endcase
	endfunction : wmask

	// field outputs arranged as the register they come from
	function automatic logic [7:0] view(input logic [4:0] r);
		case (r)
			5'h11: return {power_save_sel_o, 4'h0, audio_format_sel_o};
			5'h12: return {3'h0, dac_disable_o, 3'h0, rolloff_sel_o};
			5'h13: return {6'h0, output_invert_o};
			5'h14: return {6'h0, soft_mute_en_o};
			5'h16: return {atten_step_sel_o, 1'b0, deemph_rate_sel_o, 4'h0};
			5'h18: return left_atten_level_o;
			default: return right_atten_level_o;
		endcase
	endfunction : view

	task automatic wreg(input logic [4:0] r, input logic [7:0] v, input logic e);
		h.xfer(0, h.addr(bank, r), a);
		chk("ack index", {7'h0, e}, {7'h0, a});
		h.xfer(1, v, a);
		chk("ack write", {7'h0, e}, {7'h0, a});
		h.idle();
	endtask : wreg

	task automatic rreg(input logic [4:0] r, input logic [7:0] e);
		h.xfer(0, h.addr(bank, r), a);
		h.xfer(2, 8'h00, a);
		chk("ack read", 8'h01, {7'h0, a});
		h.idle();
		chk("rdata", e, rdata_o);
	endtask : rreg

	initial begin
		{reset_i, sw_mode_i, bank_addr_hi_i, bank_addr_lo_i} = 4'b1100;
		{zero_left_i, zero_right_i, clk_halt_i, async_detect_i} = 4'h0;
		{bank, err_total, compares, cyc} = '0;
		void'($urandom(32'h9f3e));
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		chk("fields a", 8'h00, {sample_rate_sel_o, power_save_sel_o, audio_format_sel_o,
			dac_disable_o, rolloff_sel_o});
		chk("fields b", 8'h00, {output_invert_o, soft_mute_en_o, atten_step_sel_o,
			deemph_rate_sel_o, zero1_o});
		chk("left level", 8'hff, left_atten_level_o);
		rreg(5'h15, 8'h00);
		rreg(5'h16, 8'h00);
		rreg(5'h10, 8'hc0);
		for (int i = 0; i < 24; i++) begin
			bank = 2'($urandom_range(3));
			@(negedge clk_i);
			{bank_addr_hi_i, bank_addr_lo_i} = bank;
			b = bases[$urandom_range(6)];
			d = 8'($urandom) & wmask(b);
			wreg(b, d, 1'b1);
			chk("fields", d & (b == 5'h16 ? 8'hb0 : 8'hff), view(b));
			rreg(b, d);
		end
		h.xfer(0, h.addr(bank, 5'h11), a);
		for (int k = 0; k < 4; k++)
			h.xfer(1, burst[k], a);
		h.idle();
		for (int k = 0; k < 4; k++)
			rreg(5'h11 + 5'(k), burst[k]);
		h.xfer(0, h.addr(bank, 5'h17), a);
		chk("ack hole", 8'h00, {7'h0, a});
		h.xfer(1, 8'h00, a);
		chk("ack hole write", 8'h00, {7'h0, a});
		h.xfer(0, 8'h98, a);
		chk("ack top bit", 8'h00, {7'h0, a});
		h.xfer(0, h.addr(bank + 2'h1, 5'h18), a);
		chk("ack other bank", 8'h00, {7'h0, a});
		h.idle();
		wreg(5'h18, 8'h5a, 1'b1);
		@(negedge clk_i);
		sw_mode_i = 1'b0;
		wreg(5'h18, 8'h3c, 1'b0);
		sw_mode_i = 1'b1;
		rreg(5'h18, 8'h5a);
		wreg(5'h10, 8'hbf, 1'b1);
		chk("resync", 8'h01, {7'h0, sys_resync_o});
		h.idle();
		chk("resync end", 8'h00, {7'h0, sys_resync_o});
		chk("kept level", 8'h5a, left_atten_level_o);
		rreg(5'h10, 8'hff);
		wreg(5'h10, 8'h7f, 1'b1);
		chk("default", 8'h01, {7'h0, regs_default_o});
		chk("default level", 8'hff, left_atten_level_o);
		h.idle();
		chk("default end", 8'h00, {7'h0, regs_default_o});
		rreg(5'h10, 8'hc0);
		for (int s = 0; s < 4; s++) begin
			@(negedge clk_i);
			{clk_halt_i, async_detect_i} = {s == 0, s == 1};
			{zero_left_i, zero_right_i} = {2{s == 2}};
			wreg(5'h12, (s == 3) ? 8'h10 : 8'h00, 1'b1);
			for (int e = 0; e < 2; e++) begin
				m = (e == 1) ? (4'h1 << s) : ~(4'h1 << s);
				wreg(5'h10, {2'b11, m, 2'b00}, 1'b1);
				h.idle();
				h.idle();
				chk("analog mute", 8'(e), {7'h0, analog_mute_o});
			end
		end
		@(negedge clk_i);
		{zero_left_i, zero_right_i} = 2'b10;
		h.idle();
		h.idle();
		chk("zero pins", 8'h02, {6'h0, zero1_o, zero2_o});
		rreg(5'h15, 8'h01);
		wreg(5'h16, 8'h01, 1'b1);
		h.idle();
		chk("inverted pins", 8'h01, {6'h0, zero1_o, zero2_o});
		wreg(5'h16, 8'h02, 1'b1);
		h.idle();
		chk("combined pins", 8'h01, {6'h0, zero1_o, zero2_o});
		wreg(5'h16, 8'h08, 1'b1);
		h.idle();
		chk("mute on pin", 8'h03, {6'h0, zero1_o, zero2_o});
		@(negedge clk_i);
		reset_i = 1'b1;
		@(negedge clk_i);
		reset_i = 1'b0;
		chk("reset fields", 8'h00, {6'h0, dac_disable_o, analog_mute_o});
		chk("reset pins", 8'h00, {6'h0, zero1_o, zero2_o});
		summarize();
	end
endmodule : dac_mode_control_registers_tb

`default_nettype wire

// *** testbench/host_model.sv ***
// host side of the mode register port: one strobe per cycle.
// assumes clk_i is the bank clock; strobes change at its falling edge.
`timescale 1ns/100ps
`default_nettype none

module host_model (
	input  wire logic       clk_i,
	input  wire logic       ack_i,
	output logic            idx_load_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic [7:0]      byte_o
);
	initial begin
		{idx_load_o, wr_o, rd_o} = 3'b000;
		byte_o = 8'h00;
	end

	// kind 0 index, 1 write, 2 read; ack taken at the edge that takes it
	task automatic xfer(input int kind, input logic [7:0] b, output logic a);
		@(negedge clk_i);
		idx_load_o <= (kind == 0);
		wr_o <= (kind == 1);
		rd_o <= (kind == 2);
		byte_o <= b;
		@(posedge clk_i);
		a = ack_i;
	endtask : xfer

	// released byte lines show the inverse of the last value
	task automatic idle();
		@(negedge clk_i);
		{idx_load_o, wr_o, rd_o} <= 3'b000;
		byte_o <= ~byte_o;
	endtask : idle

	function automatic logic [7:0] addr(input logic [1:0] bank, input logic [4:0] base);
		return {1'b0, bank, base};
	endfunction : addr
endmodule : host_model

`default_nettype wire
